// ---- rtl/rfc_pkg.sv ----
// Constants and carriers for the RTC status/control register block.
// Assumes a single 10 MHz core clock; no bus beyond the documented port.
package rfc_pkg;

   // *****************************************************************
   // Timing
   // *****************************************************************
   localparam int CLK_PERIOD_NS = 100;
   // Oscillator start window, in ms as printed
   localparam int OSC_START_MS = 5;
   localparam int OSC_START_CYC = OSC_START_MS * 1000000 / CLK_PERIOD_NS;
   // Transfer time figure is not given: plain default, in us
   localparam int RTC_XFER_US = 350;
   localparam int RTC_XFER_CYC = RTC_XFER_US * 1000 / CLK_PERIOD_NS;
   localparam int CNT_W = 16;

   // *****************************************************************
   // Register layout
   // *****************************************************************
   localparam logic [7:0] STAT_OFFSET = 8'h00;
   localparam int BIT_WDF = 7;
   localparam int BIT_AF = 6;
   localparam int BIT_PF = 5;
   localparam int BIT_OSCILLATOR_FAIL_FLAG = 4;
   localparam int BIT_CAL = 2;
   localparam int BIT_W = 1;
   localparam int BIT_R = 0;
   localparam logic [7:0] STAT_RESET = 8'h00;
   localparam int TIME_W = 32;

   // Host register access
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rfc_req_s;

   // Transfer sequencer states
   typedef enum logic [2:0] {
      XF_IDLE = 3'b001,
      XF_WAIT = 3'b010,
      XF_DONE = 3'b100
   } rfc_xfer_e;

endpackage : rfc_pkg

// ---- rtl/rfc_sync.sv ----
// Three-stage synchroniser with agreement filter for a pin input.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/1ps
module rfc_sync (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic din,
   output logic dout
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;

   // Chain; first stage read by second only
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
      end else if (ce) begin
         s1_reg <= din;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // Change taken once stages two and three agree
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dout <= 1'b0;
      end else if (ce && (s2_reg == s3_reg)) begin
         dout <= s3_reg;
      end
   end
endmodule : rfc_sync

// ---- rtl/rfc_top.sv ----
// RTC status/control register, time freeze and transfer control.
// Assumes rst is the power-up reset and pins are asynchronous.
//
// Function
// - Set oscillator-fail at power-up if oscillator enabled but idle 5 ms.
// - Oscillator-fail persists; a host write clears it, as does a reset with osc_fail_retained low.
// - Host clears oscillator-fail by writing zero; shown after transfer time.
// - Write-enable set freezes visible time; host writes still accepted.
// - Clearing write-enable with changed time copies it into counters.
// - Write-enable is zero after every power-up.
`timescale 1ns/1ps
module rfc_top (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire rfc_pkg::rfc_req_s req,
   input wire logic [rfc_pkg::TIME_W-1:0] time_wdata,
   input wire logic time_we,
   input wire logic osc_enable,
   input wire logic osc_running_pin,
   input wire logic vcc_low_pin,
   input wire logic osc_fail_retained,
   input wire logic tick,
   output logic [7:0] rdata,
   output logic [rfc_pkg::TIME_W-1:0] time_visible,
   output logic xfer_busy,
   output logic osc_fail_flag_out
);
   // *****************************************************************
   // Pin inputs
   // *****************************************************************
   logic osc_run_s;
   logic vcc_low_s;

   rfc_sync u_sync_osc (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .din(osc_running_pin),
      .dout(osc_run_s)
   );

   rfc_sync u_sync_vcc (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .din(vcc_low_pin),
      .dout(vcc_low_s)
   );

   // *****************************************************************
   // State
   // *****************************************************************
   logic write_en_reg;
   logic cal_reg;
   logic read_hold_reg;
   logic power_fail_flag_reg;
   logic oscillator_fail_flag_reg;
   logic osc_clr_pend_reg;
   logic time_dirty_reg;
   logic [rfc_pkg::TIME_W-1:0] counter_reg;
   logic [rfc_pkg::TIME_W-1:0] shadow_reg;
   logic [rfc_pkg::CNT_W-1:0] xfer_cnt_reg;
   logic [rfc_pkg::CNT_W-1:0] osc_cnt_reg;
   logic osc_chk_reg;
   logic cap_done_reg;
   rfc_pkg::rfc_xfer_e xf_state;

   logic reg_wr;
   logic reg_rd;
   logic xfer_end;
   assign reg_wr = req.wr && (req.addr == rfc_pkg::STAT_OFFSET);
   assign reg_rd = req.rd && (req.addr == rfc_pkg::STAT_OFFSET);
   assign xfer_end = (xf_state == rfc_pkg::XF_WAIT) &&
      (xfer_cnt_reg == '0);

   // Marks the first cycle after reset release; retained flag read there
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cap_done_reg <= 1'b0;
      end else if (ce && !cap_done_reg) begin
         cap_done_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         write_en_reg <= 1'b0;
         cal_reg <= 1'b0;
         read_hold_reg <= 1'b0;
      end else if (ce && reg_wr) begin
         write_en_reg <= req.wdata[rfc_pkg::BIT_W];
         cal_reg <= req.wdata[rfc_pkg::BIT_CAL];
         read_hold_reg <= req.wdata[rfc_pkg::BIT_R];
      end
   end

   // Startup oscillator watch over the 5 ms window
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         osc_cnt_reg <= rfc_pkg::CNT_W'(rfc_pkg::OSC_START_CYC - 1);
         osc_chk_reg <= 1'b1;
      end else if (ce && osc_chk_reg) begin
         if (osc_run_s || !osc_enable) begin
            osc_chk_reg <= 1'b0;
         end else if (osc_cnt_reg != '0) begin
            osc_cnt_reg <= osc_cnt_reg - 1'b1;
         end else begin
            osc_chk_reg <= 1'b0;
         end
      end
   end

   // Oscillator-fail flag; set wins over a pending clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         oscillator_fail_flag_reg <= 1'b0;
         osc_clr_pend_reg <= 1'b0;
      end else if (ce) begin
         if ((osc_chk_reg && osc_enable && !osc_run_s &&
              osc_cnt_reg == '0) ||
             (cap_done_reg == 1'b0 && osc_fail_retained)) begin
            oscillator_fail_flag_reg <= 1'b1;
            osc_clr_pend_reg <= 1'b0;
         end else if (osc_clr_pend_reg && xfer_end) begin
            oscillator_fail_flag_reg <= 1'b0;
            osc_clr_pend_reg <= 1'b0;
         end else if (reg_wr && !req.wdata[rfc_pkg::BIT_OSCILLATOR_FAIL_FLAG] &&
                      oscillator_fail_flag_reg) begin
            osc_clr_pend_reg <= 1'b1;
         end
      end
   end

   // power-fail flag; read clears, new drop wins
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         power_fail_flag_reg <= 1'b0;
      end else if (ce) begin
         if (vcc_low_s) begin
            power_fail_flag_reg <= 1'b1;
         end else if (reg_rd) begin
            power_fail_flag_reg <= 1'b0;
         end
      end
   end

   // Host time writes accepted only while frozen; marks time changed
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         shadow_reg <= '0;
         time_dirty_reg <= 1'b0;
      end else if (ce) begin
         if (write_en_reg && time_we) begin
            shadow_reg <= time_wdata;
            time_dirty_reg <= 1'b1;
         end else if (xf_state == rfc_pkg::XF_DONE) begin
            time_dirty_reg <= 1'b0;
         end
      end
   end

   // Transfer sequencer; one timer also times the flag clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         xf_state <= rfc_pkg::XF_IDLE;
         xfer_cnt_reg <= '0;
      end else if (ce) begin
         unique case (xf_state)
            rfc_pkg::XF_IDLE: begin
               if ((reg_wr && write_en_reg &&
                    !req.wdata[rfc_pkg::BIT_W] && time_dirty_reg) ||
                   (reg_wr && !req.wdata[rfc_pkg::BIT_OSCILLATOR_FAIL_FLAG] &&
                    oscillator_fail_flag_reg)) begin
                  xf_state <= rfc_pkg::XF_WAIT;
                  xfer_cnt_reg <=
                     rfc_pkg::CNT_W'(rfc_pkg::RTC_XFER_CYC - 1);
               end
            end
            rfc_pkg::XF_WAIT: begin
               if (xfer_cnt_reg == '0) begin
                  xf_state <= rfc_pkg::XF_DONE;
               end else begin
                  xfer_cnt_reg <= xfer_cnt_reg - 1'b1;
               end
            end
            rfc_pkg::XF_DONE: begin
               xf_state <= rfc_pkg::XF_IDLE;
            end
         endcase
      end
   end

   // counters keep running; load at transfer end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         counter_reg <= '0;
      end else if (ce) begin
         if (xf_state == rfc_pkg::XF_DONE && time_dirty_reg) begin
            counter_reg <= shadow_reg;
         end else if (tick) begin
            counter_reg <= counter_reg + 1'b1;
         end
      end
   end

   // Outputs; visible time frozen while W set
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         time_visible <= '0;
         rdata <= rfc_pkg::STAT_RESET;
         xfer_busy <= 1'b0;
         osc_fail_flag_out <= 1'b0;
      end else if (ce) begin
         if (!write_en_reg && !read_hold_reg) begin
            time_visible <= counter_reg;
         end
         rdata <= {1'b0, 1'b0, power_fail_flag_reg,
                   oscillator_fail_flag_reg, 1'b0, cal_reg,
                   write_en_reg, read_hold_reg};
         xfer_busy <= (xf_state != rfc_pkg::XF_IDLE);
         osc_fail_flag_out <= oscillator_fail_flag_reg;
      end
   end
endmodule : rfc_top

// ---- verif/rfc_top_props.sv ----
// Checker for the status/control block, bound to rfc_top.
// Assumes one clock domain and the default transfer time.
`timescale 1ns/1ps
module rfc_top_props (
   input wire logic clk,
   input wire logic rst,
   input wire rfc_pkg::rfc_req_s req,
   input wire logic [7:0] rdata,
   input wire logic [rfc_pkg::TIME_W-1:0] time_visible,
   input wire logic xfer_busy,
   input wire logic osc_fail_flag_out,
   input wire logic osc_fail_retained,
   input wire logic vcc_low_pin,
   input wire logic ce
);
   localparam int SPAN_LO = 3490;
   localparam int SPAN_HI = 3510;
   logic [15:0] busy_cnt;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Length of the busy run; read at its falling edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) busy_cnt <= 16'h0000;
      else busy_cnt <= xfer_busy ? busy_cnt + 16'h0001 : 16'h0000;
   end
   // Host write of zero to a set oscillator flag
   sequence s_osc_clear;
      ce && req.wr && req.addr == rfc_pkg::STAT_OFFSET &&
         !req.wdata[rfc_pkg::BIT_OSCILLATOR_FAIL_FLAG] && osc_fail_flag_out;
   endsequence
   a_flag_mirror: assert property (
      rdata[rfc_pkg::BIT_OSCILLATOR_FAIL_FLAG] == osc_fail_flag_out)
      else $error("status bit differs from flag");
   a_retain_load: assert property (
      $fell(rst) && osc_fail_retained |-> ##[1:3] osc_fail_flag_out)
      else $error("retained flag not restored");
   a_clear_delay: assert property (
      s_osc_clear |=> osc_fail_flag_out [*8])
      else $error("flag cleared too early");
   a_clear_busy: assert property (
      s_osc_clear |-> ##[1:2] xfer_busy)
      else $error("clear did not start timer");
   a_freeze_time: assert property (
      $rose(rdata[rfc_pkg::BIT_W]) |=> $stable(time_visible) [*4])
      else $error("time moved while frozen");
   a_xfer_span: assert property (
      $fell(xfer_busy) |-> busy_cnt >= SPAN_LO && busy_cnt <= SPAN_HI)
      else $error("transfer length wrong");
   a_power_up: assert property (
      $fell(rst) |-> rdata == 8'h00 && !xfer_busy)
      else $error("outputs not clear after reset");
   a_pf_set: assert property (
      vcc_low_pin [*8] |-> rdata[rfc_pkg::BIT_PF])
      else $error("power fail flag not set");
endmodule : rfc_top_props
bind rfc_top rfc_top_props u_props (.clk(clk), .rst(rst), .req(req),
   .rdata(rdata), .time_visible(time_visible), .xfer_busy(xfer_busy),
   .osc_fail_flag_out(osc_fail_flag_out), .ce(ce),
   .osc_fail_retained(osc_fail_retained), .vcc_low_pin(vcc_low_pin));

// ---- verif/rfc_host.sv ----
// Host model: register access and base time loading.
// Assumes requests are taken on the rising clock edge.
`timescale 1ns/1ps
module rfc_host (
   input wire logic clk,
   input wire logic [7:0] rdata,
   output rfc_pkg::rfc_req_s req = '0,
   output logic [rfc_pkg::TIME_W-1:0] time_wdata = '0,
   output logic time_we = 1'b0
);
   // One-cycle write; data inverted once released
   task automatic wr(input logic [7:0] v,
                     input logic [7:0] a = rfc_pkg::STAT_OFFSET);
      @(posedge clk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(posedge clk);
      req.wr <= 1'b0;
      req.wdata <= ~v;
   endtask : wr
   // Value as it stands when the read is taken
   task automatic rd(output logic [7:0] v);
      @(posedge clk);
      v = rdata;
      req.rd <= 1'b1;
      @(posedge clk);
      req.rd <= 1'b0;
   endtask : rd
   // New base time, only honoured while frozen
   task automatic load_time(input logic [rfc_pkg::TIME_W-1:0] t);
      @(posedge clk);
      time_wdata <= t;
      time_we <= 1'b1;
      @(posedge clk);
      time_we <= 1'b0;
      time_wdata <= ~t;
   endtask : load_time
   // wait transfer time
   // A store started earlier could save the old base time
   task automatic settle;
      repeat (rfc_pkg::RTC_XFER_CYC + 4) @(posedge clk);
   endtask : settle
endmodule : rfc_host

// ---- verif/tb_top.sv ----
// Bench for rfc_top driven through the host model.
// Assumes a 10 MHz clock and the default transfer time.
`timescale 1ns/1ps
module tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic tick = 1'b0;
   logic tick_on = 1'b0;
   logic osc_en = 1'b1;
   logic osc_run = 1'b0;
   logic vcc_low = 1'b0;
   logic retained = 1'b0;
   rfc_pkg::rfc_req_s req;
   logic [31:0] wdata, vis, n_tick;
   logic we, busy, oscillator_fail_flag;
   logic [7:0] rdata, v;
   int n_fail = 0;
   int comparisons = 0;
   rfc_host host (.clk(clk), .rdata(rdata), .req(req),
      .time_wdata(wdata), .time_we(we));
   rfc_top uut (.clk(clk), .rst(rst), .ce(ce), .req(req),
      .time_wdata(wdata), .time_we(we), .osc_enable(osc_en),
      .osc_running_pin(osc_run), .vcc_low_pin(vcc_low),
      .osc_fail_retained(retained), .tick(tick), .rdata(rdata),
      .time_visible(vis), .xfer_busy(busy), .osc_fail_flag_out(oscillator_fail_flag));
   initial begin
      forever #50 clk = ~clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic stop_test;
      $display("fails %0d comparisons %0d", n_fail, comparisons);
      if (n_fail == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : stop_test
   // Ticks on alternate cycles; own count is the expected time
   always @(posedge clk) begin
      tick <= tick_on & ~tick;
      n_tick <= rst ? 32'h0 : n_tick + {31'h0, tick};
   end
   // Hang guard, well past the longest expected run
   initial begin
      repeat (80000) @(posedge clk);
      n_fail++;
      stop_test();
   end
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      host.rd(v);
      chk(v, 8'h00);
      repeat (rfc_pkg::OSC_START_CYC + 20) @(posedge clk);
      host.rd(v);
      chk(v, 8'h10);
      chk({31'h0, oscillator_fail_flag}, 32'h1);
      osc_run <= 1'b1;
      host.wr(8'h00);
      repeat (2) @(posedge clk);
      host.rd(v);
      chk(v, 8'h10);
      host.settle();
      host.rd(v);
      chk(v, 8'h00);
      host.wr(8'h02, 8'h01);
      repeat (2) @(posedge clk);
      host.rd(v);
      chk(v, 8'h00);
      // write lost while clock enable is low
      ce <= 1'b0;
      host.wr(8'h02);
      ce <= 1'b1;
      repeat (2) @(posedge clk);
      host.rd(v);
      chk(v, 8'h00);
      host.wr(8'h02);
      tick_on <= 1'b1;
      repeat (40) @(posedge clk);
      tick_on <= 1'b0;
      repeat (4) @(posedge clk);
      chk(vis, 32'h0);
      host.wr(8'h00);
      repeat (6) @(posedge clk);
      chk(vis, n_tick);
      host.wr(8'h05);
      repeat (2) @(posedge clk);
      host.rd(v);
      chk(v, 8'h05);
      host.wr(8'h02);
      host.load_time(32'h1234_5678);
      host.wr(8'h00);
      repeat (2) @(posedge clk);
      chk({31'h0, busy}, 32'h1);
      host.settle();
      chk(vis, 32'h1234_5678);
      vcc_low <= 1'b1;
      repeat (10) @(posedge clk);
      vcc_low <= 1'b0;
      repeat (6) @(posedge clk);
      host.rd(v);
      chk(v, 8'h20);
      repeat (3) @(posedge clk);
      host.rd(v);
      chk(v, 8'h00);
      retained <= 1'b1;
      osc_en <= 1'b0;
      osc_run <= 1'b0;
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      host.rd(v);
      chk(v, 8'h10);
      chk({31'h0, oscillator_fail_flag}, 32'h1);
      stop_test();
   end
endmodule : tb_top
